// >>> logic/charger_pkg.sv
// Shared constants, register layout and types for the battery charger control block.
package charger_pkg;

  localparam int unsigned MA_W = 10;

  // Register byte offsets.
  localparam logic [7:0] OFF_CHARGER_CTRL = 8'h00;
  localparam logic [7:0] OFF_SUPPLY_5V    = 8'h04;
  localparam logic [7:0] OFF_STATUS       = 8'h08;
  localparam logic [7:0] OFF_SETPOINT     = 8'h0C;

  // Field positions.
  localparam int unsigned POS_CHARGE_CODE   = 0;
  localparam int unsigned POS_STOP_CODE     = 8;
  localparam int unsigned POS_CHARGER_OFF   = 16;
  localparam int unsigned POS_MASTER_LIMIT  = 0;
  localparam int unsigned POS_MASTER_PD     = 8;
  localparam int unsigned POS_LINEAR_REG_5V = 12;
  localparam int unsigned POS_DONE_FLAG     = 0;
  localparam int unsigned POS_CHARGER_EN    = 1;
  localparam int unsigned POS_STATE         = 4;
  localparam int unsigned POS_APPLIED_MA    = 16;
  localparam int unsigned POS_TARGET_MA     = 0;
  localparam int unsigned POS_STOP_MA       = 16;

  // Reset values.
  localparam logic [5:0] RST_CHARGE_CODE  = 6'h00;
  localparam logic [3:0] RST_STOP_CODE    = 4'h0;
  localparam logic       RST_CHARGER_OFF  = 1'b1;
  localparam logic [5:0] RST_MASTER_LIMIT = 6'h00;
  localparam logic       RST_MASTER_PD    = 1'b1;
  localparam logic       RST_LINEAR_REG_5V = 1'b1;

  // Weight in mA of each code bit, bit 0 first.
  localparam logic [MA_W-1:0] WEIGHT_MA [6] = '{10'd10, 10'd20, 10'd50, 10'd100, 10'd200, 10'd400};

  typedef enum logic [2:0] {
    ST_OFF      = 3'b001,
    ST_CHARGING = 3'b010,
    ST_FULL     = 3'b100
  } charge_state_e;

  // Sum of the weights of the set bits of a code; stop codes use the low four bits only.
  function automatic logic [MA_W-1:0] code_to_ma(input logic [5:0] code);
    logic [MA_W-1:0] sum;
    sum = '0;
    for (int i = 0; i < 6; i++) begin
      if (code[i]) begin
        sum = sum + WEIGHT_MA[i];
      end
    end
    return sum;
  endfunction

endpackage

// >>> logic/setpoint_if.sv
// Codes and their decoded currents passed between the control core and the decoder.
`timescale 1ns/10ps
interface setpoint_if;
  logic [5:0]  charge_code;
  logic [3:0]  stop_code;
  logic [5:0]  master_code;
  logic [9:0]  charge_ma;
  logic [9:0]  stop_ma;
  logic [9:0]  master_ma;

  modport decoder (
    input  charge_code,
    input  stop_code,
    input  master_code,
    output charge_ma,
    output stop_ma,
    output master_ma
  );

  modport control (
    output charge_code,
    output stop_code,
    output master_code,
    input  charge_ma,
    input  stop_ma,
    input  master_ma
  );
endinterface

// >>> logic/current_code_decoder.sv
// Combinational decoder from bit-weighted current codes to milliamps.
`timescale 1ns/10ps
module current_code_decoder (
  setpoint_if.decoder sp
);
  import charger_pkg::*;

  always_comb begin
    sp.charge_ma = code_to_ma(sp.charge_code);
    sp.stop_ma   = code_to_ma({2'b00, sp.stop_code});
    sp.master_ma = code_to_ma(sp.master_code);
  end
endmodule

// >>> logic/battery_charger_control.sv
// Battery charger control: APB registers, master gating, rail priority and full detection.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module battery_charger_control #(
  parameter logic [9:0] SUPPLY_BUDGET_MA = 10'd1000
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      supply_5v_present_i,
  input  wire logic [charger_pkg::MA_W-1:0] battery_current_ma_i,
  input  wire logic [charger_pkg::MA_W-1:0] rail_current_ma_i,
  output logic                           charger_enable_o,
  output logic      [charger_pkg::MA_W-1:0] charger_current_ma_o,
  output logic      [charger_pkg::MA_W-1:0] stop_current_ma_o,
  output logic                           charge_done_o,
  output logic                           linear_regulator_5v_o
);
  import charger_pkg::*;

  typedef struct packed {
    charge_state_e   state;
    logic [5:0]      charge_current_code;
    logic [3:0]      stop_current_code;
    logic            charger_off_bit;
    logic [5:0]      master_current_limit;
    logic            master_power_down;
    logic            linear_regulator_5v;
    logic            done_flag;
    logic            charger_enable;
    logic [MA_W-1:0] applied_ma;
    logic [MA_W-1:0] stop_ma;
    logic [31:0]     prdata;
  } ctl_s;

  ctl_s ctl_q;
  ctl_s ctl_d;

  logic [1:0] rst_sync_q;
  logic       rst_n;

  setpoint_if sp ();

  current_code_decoder u_decoder (
    .sp (sp.decoder)
  );

  // Release is synchronised so that no register leaves reset on a different edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign sp.charge_code = ctl_q.charge_current_code;
  assign sp.stop_code   = ctl_q.stop_current_code;
  assign sp.master_code = ctl_q.master_current_limit;

  function automatic logic [MA_W-1:0] min_ma(input logic [MA_W-1:0] a, input logic [MA_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  logic            setup;
  logic            access_wr;
  logic            mapped;
  logic            enable_ok;
  logic            at_stop;
  logic [MA_W-1:0] spare_ma;
  logic [MA_W-1:0] target_ma;

  assign setup     = psel_i && !penable_i;
  assign access_wr = psel_i && penable_i && pwrite_i;
  assign mapped    = (paddr_i == OFF_CHARGER_CTRL) || (paddr_i == OFF_SUPPLY_5V) ||
                     (paddr_i == OFF_STATUS) || (paddr_i == OFF_SETPOINT);

  always_comb begin
    ctl_d = ctl_q;

    // The rail regulator keeps whatever it draws; the charger gets only what is left.
    if (rail_current_ma_i < SUPPLY_BUDGET_MA) begin
      spare_ma = SUPPLY_BUDGET_MA - rail_current_ma_i;
    end else begin
      spare_ma = '0;
    end
    target_ma = min_ma(min_ma(sp.charge_ma, sp.master_ma), spare_ma);
    enable_ok = supply_5v_present_i && !ctl_q.master_power_down &&
                !ctl_q.charger_off_bit;
    at_stop   = battery_current_ma_i <= sp.stop_ma;

    // Register writes take effect at the access edge.
    if (access_wr) begin
      case (paddr_i)
        OFF_CHARGER_CTRL: begin
          ctl_d.charge_current_code = pwdata_i[POS_CHARGE_CODE +: 6];
          ctl_d.stop_current_code   = pwdata_i[POS_STOP_CODE +: 4];
          ctl_d.charger_off_bit     = pwdata_i[POS_CHARGER_OFF];
        end
        OFF_SUPPLY_5V: begin
          ctl_d.master_current_limit = pwdata_i[POS_MASTER_LIMIT +: 6];
          ctl_d.master_power_down    = pwdata_i[POS_MASTER_PD];
          ctl_d.linear_regulator_5v  = pwdata_i[POS_LINEAR_REG_5V];
        end
        OFF_STATUS: begin
          if (pwdata_i[POS_DONE_FLAG]) begin
            ctl_d.done_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (ctl_q.state)
      ST_OFF: begin
        if (enable_ok) begin
          ctl_d.state = ST_CHARGING;
        end
      end
      ST_CHARGING: begin
        if (!enable_ok) begin
          ctl_d.state = ST_OFF;
        end else if (at_stop) begin
          ctl_d.state     = ST_FULL;
          ctl_d.done_flag = 1'b1;
        end
      end
      ST_FULL: begin
        // Charging carries on until firmware powers the charger down or the 5 V supply goes away.
        if (!enable_ok) begin
          ctl_d.state = ST_OFF;
        end
      end
      default: begin
        ctl_d.state = ST_OFF;
      end
    endcase
    // A set in the same cycle as a clear is kept.
    if (ctl_q.state == ST_CHARGING && enable_ok && at_stop) begin
      ctl_d.done_flag = 1'b1;
    end

    ctl_d.charger_enable = enable_ok;
    ctl_d.applied_ma     = enable_ok ? target_ma : '0;
    ctl_d.stop_ma        = sp.stop_ma;

    // Read data is captured in the setup cycle so the access phase needs no wait state.
    if (setup) begin
      ctl_d.prdata = 32'h0000_0000;
      case (paddr_i)
        OFF_CHARGER_CTRL: begin
          ctl_d.prdata[POS_CHARGE_CODE +: 6] = ctl_q.charge_current_code;
          ctl_d.prdata[POS_STOP_CODE +: 4]   = ctl_q.stop_current_code;
          ctl_d.prdata[POS_CHARGER_OFF]      = ctl_q.charger_off_bit;
        end
        OFF_SUPPLY_5V: begin
          ctl_d.prdata[POS_MASTER_LIMIT +: 6] = ctl_q.master_current_limit;
          ctl_d.prdata[POS_MASTER_PD]         = ctl_q.master_power_down;
          ctl_d.prdata[POS_LINEAR_REG_5V]     = ctl_q.linear_regulator_5v;
        end
        OFF_STATUS: begin
          ctl_d.prdata[POS_DONE_FLAG]        = ctl_q.done_flag;
          ctl_d.prdata[POS_CHARGER_EN]       = ctl_q.charger_enable;
          ctl_d.prdata[POS_STATE +: 3]       = ctl_q.state;
          ctl_d.prdata[POS_APPLIED_MA +: MA_W] = ctl_q.applied_ma;
        end
        OFF_SETPOINT: begin
          ctl_d.prdata[POS_TARGET_MA +: MA_W] = sp.charge_ma;
          ctl_d.prdata[POS_STOP_MA +: MA_W]   = sp.stop_ma;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q.state                <= ST_OFF;
      ctl_q.charge_current_code  <= RST_CHARGE_CODE;
      ctl_q.stop_current_code    <= RST_STOP_CODE;
      ctl_q.charger_off_bit      <= RST_CHARGER_OFF;
      ctl_q.master_current_limit <= RST_MASTER_LIMIT;
      ctl_q.master_power_down    <= RST_MASTER_PD;
      ctl_q.linear_regulator_5v  <= RST_LINEAR_REG_5V;
      ctl_q.done_flag            <= 1'b0;
      ctl_q.charger_enable       <= 1'b0;
      ctl_q.applied_ma           <= '0;
      ctl_q.stop_ma              <= '0;
      ctl_q.prdata               <= 32'h0000_0000;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign pready_o             = 1'b1;
  assign pslverr_o            = psel_i && penable_i && !mapped;
  assign prdata_o             = ctl_q.prdata;
  assign charger_enable_o     = ctl_q.charger_enable;
  assign charger_current_ma_o = ctl_q.applied_ma;
  assign stop_current_ma_o    = ctl_q.stop_ma;
  assign charge_done_o        = ctl_q.done_flag;
  assign linear_regulator_5v_o = ctl_q.linear_regulator_5v;
endmodule

// >>> tb/battery_charger_control_properties.sv
// Port-level checks of the battery charger control block.
`timescale 1ns/10ps
module battery_charger_control_properties #(
  parameter logic [9:0] SUPPLY_BUDGET_MA = 10'd1000
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        supply_5v_present_i,
  input wire logic [9:0]  battery_current_ma_i,
  input wire logic [9:0]  rail_current_ma_i,
  input wire logic        charger_enable_o,
  input wire logic [9:0]  charger_current_ma_o,
  input wire logic [9:0]  stop_current_ma_o,
  input wire logic        charge_done_o,
  input wire logic        linear_regulator_5v_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_charge_max: assert property (charger_current_ma_o <= 10'd780)
    else $error("charge current above code range");
  chk_stop_max: assert property (stop_current_ma_o <= 10'd180)
    else $error("stop current above code range");
  chk_done_cause: assert property ($rose(charge_done_o) |->
    $past(battery_current_ma_i) <= stop_current_ma_o) else $error("done without cause");
  chk_off_no_current: assert property (!charger_enable_o |-> charger_current_ma_o == 10'd0)
    else $error("current while disabled");
  chk_needs_5v: assert property (charger_enable_o |-> $past(supply_5v_present_i))
    else $error("enabled without 5 V");
  chk_rail_first: assert property (charger_enable_o |-> charger_current_ma_o == 10'd0 ||
    {1'b0, charger_current_ma_o} + {1'b0, $past(rail_current_ma_i)} <= {1'b0, SUPPLY_BUDGET_MA})
    else $error("charger exceeds rail share");
  chk_regulator_write: assert property ($changed(linear_regulator_5v_o) |->
    $past(psel_i && penable_i && pwrite_i && paddr_i == 8'h04)) else $error("regulator changed");
  chk_done_sticky: assert property (charge_done_o && !(psel_i && penable_i && pwrite_i)
    |=> charge_done_o) else $error("done flag dropped");
endmodule
bind battery_charger_control battery_charger_control_properties #(
  .SUPPLY_BUDGET_MA(SUPPLY_BUDGET_MA)
) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .supply_5v_present_i(supply_5v_present_i),
  .battery_current_ma_i(battery_current_ma_i), .rail_current_ma_i(rail_current_ma_i),
  .charger_enable_o(charger_enable_o), .charger_current_ma_o(charger_current_ma_o),
  .stop_current_ma_o(stop_current_ma_o), .charge_done_o(charge_done_o),
  .linear_regulator_5v_o(linear_regulator_5v_o));

// >>> tb/battery_charger_control_test.sv
// Self-checking bench for the battery charger control block.
`timescale 1ns/10ps
module battery_charger_control_test;
  import charger_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        supply_5v_present_i = 1'b1;
  logic [9:0]  battery_current_ma_i = 10'd500;
  logic [9:0]  rail_current_ma_i = 10'd0;
  logic        charger_enable_o;
  logic [9:0]  charger_current_ma_o;
  logic [9:0]  stop_current_ma_o;
  logic        charge_done_o;
  logic        linear_regulator_5v_o;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  battery_charger_control dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .supply_5v_present_i(supply_5v_present_i), .battery_current_ma_i(battery_current_ma_i),
    .rail_current_ma_i(rail_current_ma_i), .charger_enable_o(charger_enable_o),
    .charger_current_ma_o(charger_current_ma_o), .stop_current_ma_o(stop_current_ma_o),
    .charge_done_o(charge_done_o), .linear_regulator_5v_o(linear_regulator_5v_o));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang in the bus handshake ends the run here.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One idle edge precedes every setup so that no strobe is assigned twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(name, rd, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_reset();
    rdchk("ctrl", OFF_CHARGER_CTRL, 32'h0001_0000);
    rdchk("supply", OFF_SUPPLY_5V, 32'h0000_1100);
    check("regulator", linear_regulator_5v_o, 32'h1);
    check("enable", charger_enable_o, 32'h0);
  endtask
  task automatic t_decode();
    logic [5:0] cc [4] = '{6'h34, 6'h30, 6'h3F, 6'h01};
    logic [3:0] sc [4] = '{4'hA, 4'h5, 4'hF, 4'h1};
    logic [9:0] cm [4] = '{10'd650, 10'd600, 10'd780, 10'd10};
    logic [9:0] sm [4] = '{10'd120, 10'd60, 10'd180, 10'd10};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CHARGER_CTRL, {15'h0, 1'b1, 4'h0, sc[i], 2'h0, cc[i]});
      rdchk("setpoint", OFF_SETPOINT, {6'h0, sm[i], 6'h0, cm[i]});
      check("stop_ma", stop_current_ma_o, {22'h0, sm[i]});
    end
  endtask
  // Battery voltage sensing and the detect wait live outside this block.
  task automatic t_gate();
    wr(OFF_CHARGER_CTRL, 32'h0000_0530);
    settle();
    check("en_master_off", charger_enable_o, 32'h0);
    wr(OFF_SUPPLY_5V, 32'h0000_1003);
    settle();
    check("en_on", charger_enable_o, 32'h1);
    check("ma_30", charger_current_ma_o, 32'd30);
    wr(OFF_SUPPLY_5V, 32'h0000_103F);
    settle();
    check("ma_600", charger_current_ma_o, 32'd600);
    rail_current_ma_i <= 10'd900;
    settle();
    check("ma_rail", charger_current_ma_o, 32'd100);
    rail_current_ma_i <= 10'd0;
    supply_5v_present_i <= 1'b0;
    settle();
    check("en_no5v", charger_enable_o, 32'h0);
    supply_5v_present_i <= 1'b1;
    settle();
  endtask
  task automatic t_done();
    battery_current_ma_i <= 10'd61;
    settle();
    check("done_61", charge_done_o, 32'h0);
    battery_current_ma_i <= 10'd60;
    settle();
    check("done_60", charge_done_o, 32'h1);
    rdchk("status", OFF_STATUS, 32'h0258_0043);
    battery_current_ma_i <= 10'd500;
    wr(OFF_STATUS, 32'h1);
    settle();
    check("done_clr", charge_done_o, 32'h0);
    wr(OFF_CHARGER_CTRL, 32'h0001_0530);
    settle();
    check("en_off", charger_enable_o, 32'h0);
    check("ma_off", charger_current_ma_o, 32'h0);
  endtask
  task automatic t_misc();
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 8'hF0, 32'h0, rd, err);
    check("bad_rd", rd, 32'h0);
    check("bad_err", {31'h0, err}, 32'h1);
    wr(OFF_SUPPLY_5V, 32'h0000_0100);
    settle();
    check("regulator_off", linear_regulator_5v_o, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_decode();
    t_gate();
    t_done();
    t_misc();
    wrap_up();
  end
endmodule
